// file: pkg/apw_pkg.sv
// constants shared by the auxiliary pwm timer block
`default_nettype none
package apw_pkg;
   localparam logic [7:0] APW_PER0_OFS = 8'h00;
   localparam logic [7:0] APW_PER1_OFS = 8'h04;
   localparam logic [7:0] APW_ON0_OFS = 8'h08;
   localparam logic [7:0] APW_ON1_OFS = 8'h0C;
   localparam logic [7:0] APW_MODE_OFS = 8'h10;
   localparam logic [7:0] APW_PSEL_OFS = 8'h14;
   localparam logic [7:0] APW_IOD1_OFS = 8'h18;
   localparam logic [7:0] APW_STAT_OFS = 8'h1C;
   localparam int APW_MODE_BIT = 8;
   localparam int APW_ROUTE_BIT = 1;
   localparam int APW_PSEL_CH1_BIT = 7;
   localparam logic [7:0] APW_PER_RST = 8'hFF;
   localparam logic [7:0] APW_ON_RST = 8'h00;
   localparam logic [7:0] APW_PSEL_RST = 8'hFF;
   localparam logic [1:0] APW_IOD1_RST = 2'h2;
   localparam logic [1:0] APW_RESP_OK = 2'h0;
   localparam logic [1:0] APW_RESP_ERR = 2'h2;
endpackage
`default_nettype wire

// file: pkg/apw_ch_if.sv
// interface carrying one channel's settings and state between top and channel
`default_nettype none
interface apw_ch_if;
   logic [7:0] on_time;
   logic [7:0] count;
   logic start;
   logic pwm;
   modport ctl (output on_time, output count, output start, input pwm);
   modport ch (input on_time, input count, input start, output pwm);
endinterface
`default_nettype wire

// file: core/apw_channel.sv
// one auxiliary pwm output stage: latches on-time at cycle start, compares
`default_nettype none
module apw_channel (
   input wire logic mclk_i, // system clock
   input wire logic sys_rst_i, // synchronous reset
   input wire logic step_i, // two-cycle step strobe
   apw_ch_if.ch chn // channel settings and output
);
   import apw_pkg::*;
   logic [7:0] on_act_r;
   logic pwm_r;
   // on-time only latched at the first step of a cycle, so mid-cycle writes wait
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         on_act_r <= APW_ON_RST;
      end else if (chn.start) begin
         on_act_r <= chn.on_time;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pwm_r <= 1'b0;
      end else if (chn.start) begin
         pwm_r <= (chn.on_time != 8'h00);
      end else if (step_i) begin
         // judged on the count the step moves to, so the high phase is exactly the on-time
         pwm_r <= (({1'b0, chn.count} + 9'h001) < {1'b0, on_act_r});
      end
   end
   assign chn.pwm = pwm_r;
   a_on_zero_low: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (chn.start && chn.on_time == 8'h00) |=> !pwm_r) else $error("zero on-time drove high");
   a_on_nz_high: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (chn.start && chn.on_time != 8'h00) |=> pwm_r) else $error("cycle start not high");
endmodule
`default_nettype wire

// file: core/apw_top.sv
// auxiliary dual pwm timer with axi4-lite register slave
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
module apw_top (
   input wire logic mclk_i, // 50 MHz clock
   input wire logic sys_rst_i, // synchronous active-high reset
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic gp_line_seven_i, // gpio level for shared pin of second output
   input wire logic gp_line_eight_i, // gpio level for shared pin of first output
   output logic pwm_out_first_o, // pin of first output
   output logic pwm_out_second_o, // pin of second output
   output logic [7:0] pin_function_select_o // pin-select bits for other shared pins
);
   import apw_pkg::*;

   typedef enum logic [1:0] {
      APW_W_IDLE = 2'b01,
      APW_W_RESP = 2'b10
   } apw_wst_e;

   logic [7:0] first_channel_period_r;
   logic [7:0] second_channel_period_or_offset_r;
   logic [7:0] first_channel_on_time_r;
   logic [7:0] second_channel_on_time_r;
   logic mode_indep_r;
   logic [7:0] pin_function_select_r;
   logic [1:0] io_data_high_reg_r;
   apw_wst_e wst_r;
   logic aw_held_r;
   logic w_held_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic do_write;
   logic wr_map;
   logic per_wr;
   logic half_r;
   logic step;
   logic [7:0] cnt0_r;
   logic [7:0] cnt1_r;
   logic off_run_r;
   logic start0;
   logic start1;
   logic [7:0] per1_eff;
   logic gp7_m_r;
   logic gp7_s_r;
   logic gp8_m_r;
   logic gp8_s_r;

   apw_ch_if ch0 ();
   apw_ch_if ch1 ();

   // ---------------- axi4-lite write path ----------------
   assign s_axi_awready = (wst_r == APW_W_IDLE) && !aw_held_r;
   assign s_axi_wready = (wst_r == APW_W_IDLE) && !w_held_r;
   assign do_write = (wst_r == APW_W_IDLE) && aw_held_r && w_held_r;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         aw_held_r <= 1'b0;
         awaddr_r <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         w_held_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         wst_r <= APW_W_IDLE;
         bresp_r <= APW_RESP_OK;
      end else begin
         case (wst_r)
            APW_W_IDLE: begin
               if (do_write) begin
                  wst_r <= APW_W_RESP;
                  bresp_r <= wr_map ? APW_RESP_OK : APW_RESP_ERR;
               end
            end
            APW_W_RESP: begin
               if (s_axi_bready) begin
                  wst_r <= APW_W_IDLE;
               end
            end
            default: wst_r <= APW_W_IDLE;
         endcase
      end
   end
   assign s_axi_bvalid = (wst_r == APW_W_RESP);
   assign s_axi_bresp = bresp_r;

   always_comb begin
      case (awaddr_r)
         APW_PER0_OFS, APW_PER1_OFS, APW_ON0_OFS, APW_ON1_OFS,
         APW_MODE_OFS, APW_PSEL_OFS, APW_IOD1_OFS, APW_STAT_OFS: wr_map = 1'b1;
         default: wr_map = 1'b0;
      endcase
   end

   // period registers accept any value, 0 gives the two-clock minimum
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         first_channel_period_r <= APW_PER_RST;
         second_channel_period_or_offset_r <= APW_PER_RST;
         first_channel_on_time_r <= APW_ON_RST;
         second_channel_on_time_r <= APW_ON_RST;
      end else if (do_write && wstrb_r[0]) begin
         case (awaddr_r)
            APW_PER0_OFS: first_channel_period_r <= wdata_r[7:0];
            APW_PER1_OFS: second_channel_period_or_offset_r <= wdata_r[7:0];
            APW_ON0_OFS: first_channel_on_time_r <= wdata_r[7:0];
            APW_ON1_OFS: second_channel_on_time_r <= wdata_r[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mode_indep_r <= 1'b0;
         pin_function_select_r <= APW_PSEL_RST;
         io_data_high_reg_r <= APW_IOD1_RST;
      end else if (do_write) begin
         if (awaddr_r == APW_MODE_OFS && wstrb_r[1]) begin
            mode_indep_r <= wdata_r[APW_MODE_BIT];
         end
         if (awaddr_r == APW_PSEL_OFS && wstrb_r[0]) begin
            pin_function_select_r <= wdata_r[7:0];
         end
         if (awaddr_r == APW_IOD1_OFS && wstrb_r[0]) begin
            io_data_high_reg_r <= wdata_r[1:0];
         end
      end
   end

   // ---------------- axi4-lite read path ----------------
   assign s_axi_arready = !rvalid_r;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= APW_RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rresp_r <= APW_RESP_OK;
         case (s_axi_araddr)
            APW_PER0_OFS: rdata_r <= {24'h000000, first_channel_period_r};
            APW_PER1_OFS: rdata_r <= {24'h000000, second_channel_period_or_offset_r};
            APW_ON0_OFS: rdata_r <= {24'h000000, first_channel_on_time_r};
            APW_ON1_OFS: rdata_r <= {24'h000000, second_channel_on_time_r};
            APW_MODE_OFS: rdata_r <= {23'h0, mode_indep_r, 8'h00};
            APW_PSEL_OFS: rdata_r <= {24'h000000, pin_function_select_r};
            APW_IOD1_OFS: rdata_r <= {30'h0, io_data_high_reg_r};
            APW_STAT_OFS: rdata_r <= {14'h0, ch1.pwm, ch0.pwm, cnt1_r, cnt0_r};
            default: begin
               rdata_r <= 32'h0000_0000;
               rresp_r <= APW_RESP_ERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // ---------------- timers ----------------
   assign per_wr = do_write && wstrb_r[0] && (awaddr_r == APW_PER0_OFS || awaddr_r == APW_PER1_OFS);

   // step strobe every second clock; realigned by a period write
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || per_wr) begin
         half_r <= 1'b0;
      end else begin
         half_r <= !half_r;
      end
   end
   assign step = half_r;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || per_wr) begin
         cnt0_r <= 8'h00;
      end else if (step) begin
         cnt0_r <= (cnt0_r >= first_channel_period_r) ? 8'h00 : cnt0_r + 8'h01;
      end
   end

   // offset mode: second counter waits the offset after the first rising edge
   assign per1_eff = mode_indep_r ? second_channel_period_or_offset_r : first_channel_period_r;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || per_wr) begin
         cnt1_r <= 8'h00;
         off_run_r <= 1'b0;
      end else if (step) begin
         if (mode_indep_r || off_run_r) begin
            cnt1_r <= (cnt1_r >= per1_eff) ? 8'h00 : cnt1_r + 8'h01;
            off_run_r <= off_run_r;
         end else if (cnt1_r >= second_channel_period_or_offset_r) begin
            // offset expires; relies on offset < first period
            cnt1_r <= 8'h00;
            off_run_r <= 1'b1;
         end else begin
            cnt1_r <= cnt1_r + 8'h01;
         end
      end
   end

   // a period write opens a fresh cycle at once; in offset mode the second channel still waits the offset
   assign start0 = per_wr || (step && (cnt0_r >= first_channel_period_r));
   assign start1 = (per_wr && mode_indep_r) || (step && (mode_indep_r || off_run_r ? (cnt1_r >= per1_eff)
                                                      : (cnt1_r >= second_channel_period_or_offset_r)));

   assign ch0.on_time = first_channel_on_time_r;
   assign ch0.count = cnt0_r;
   assign ch0.start = start0;
   assign ch1.on_time = second_channel_on_time_r;
   // parked at all ones during the offset wait so the second output stays low until its first start
   assign ch1.count = (mode_indep_r || off_run_r) ? cnt1_r : 8'hFF;
   assign ch1.start = start1;

   apw_channel u_ch0 (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .step_i(step), .chn(ch0.ch));
   apw_channel u_ch1 (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .step_i(step), .chn(ch1.ch));

   // ---------------- pin muxing ----------------
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         gp7_m_r <= 1'b0;
         gp7_s_r <= 1'b0;
         gp8_m_r <= 1'b0;
         gp8_s_r <= 1'b0;
      end else begin
         gp7_m_r <= gp_line_seven_i;
         gp7_s_r <= gp7_m_r;
         gp8_m_r <= gp_line_eight_i;
         gp8_s_r <= gp8_m_r;
      end
   end

   assign pwm_out_second_o = pin_function_select_r[APW_PSEL_CH1_BIT] ? gp7_s_r : ch1.pwm;
   assign pwm_out_first_o = io_data_high_reg_r[APW_ROUTE_BIT] ? gp8_s_r : ch0.pwm;
   assign pin_function_select_o = pin_function_select_r;

   // ---------------- checks ----------------
   sequence s_per_write;
      per_wr;
   endsequence
   sequence s_timers_cleared;
      cnt0_r == 8'h00 && cnt1_r == 8'h00;
   endsequence
   a_period_write_clr: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      s_per_write |=> s_timers_cleared) else $error("period write did not clear timers");
   a_step_every_two: assert property (@(posedge mclk_i) disable iff (sys_rst_i || per_wr)
      step |=> !step) else $error("step strobe too frequent");
   a_cnt0_wrap: assert property (@(posedge mclk_i) disable iff (sys_rst_i || per_wr)
      (step && cnt0_r == first_channel_period_r) |=> cnt0_r == 8'h00) else $error("first timer missed wrap");
   a_cnt0_bound: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      $stable(first_channel_period_r) && cnt0_r <= first_channel_period_r |=> cnt0_r <= first_channel_period_r)
      else $error("first timer overran period");
   a_offset_share: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (!mode_indep_r && off_run_r && cnt1_r <= first_channel_period_r)
      |=> cnt1_r <= first_channel_period_r) else $error("offset mode period wrong");
   a_indep_own: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (mode_indep_r && cnt1_r <= second_channel_period_or_offset_r)
      |=> cnt1_r <= second_channel_period_or_offset_r) else $error("independent period wrong");
   a_offset_start: assert property (@(posedge mclk_i) disable iff (sys_rst_i || per_wr)
      (!mode_indep_r && !off_run_r && step && cnt1_r == second_channel_period_or_offset_r) |=> off_run_r)
      else $error("offset did not expire");
   a_route_first: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      !io_data_high_reg_r[APW_ROUTE_BIT] |-> pwm_out_first_o == ch0.pwm) else $error("first output not routed");
   a_route_second: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      !pin_function_select_r[APW_PSEL_CH1_BIT] |-> pwm_out_second_o == ch1.pwm)
      else $error("second output not routed");
   a_full_duty: assert property (@(posedge mclk_i) disable iff (sys_rst_i || per_wr)
      (start0 && first_channel_on_time_r > first_channel_period_r) ##1 (!start0 [*2]) |-> ch0.pwm)
      else $error("full duty not held");
endmodule
`default_nettype wire

// file: tb/apw_load_model.sv
// pulse-timing model of the load that one pwm pin drives
`default_nettype none
module apw_load_model (
   input wire logic clk_i, // bench clock
   input wire logic pin_i, // pwm pin under observation
   output int per_o, // clocks between the last two rising edges
   output int hi_o, // clocks of the last high phase
   output int rise_o // cycle stamp of the last rising edge
);
   timeunit 1ns;
   timeprecision 1ps;
   int cyc = 0;
   logic prev = 1'b0;
   // a filter load only listens, so the model measures and never drives back
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      prev <= pin_i;
      if (pin_i && !prev) begin
         per_o <= cyc - rise_o;
         rise_o <= cyc;
      end
      if (!pin_i && prev) begin
         hi_o <= cyc - rise_o;
      end
   end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the dual auxiliary pwm timer
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import apw_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} apw_tb_reg_s;
   typedef struct {logic m; logic [7:0] p0; logic [7:0] c0; logic [7:0] p1; logic [7:0] c1;} apw_tb_pwm_s;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] awaddr, araddr, psel;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   logic awvalid, wvalid, bready, arvalid, rready, gp7, gp8;
   logic awready, wready, bvalid, arready, rvalid, pin0, pin1;
   int n_fail = 0, compares = 0, cyc = 0;
   int per0, hi0, r0, per1, hi1, r1, e0, e1;
   apw_tb_reg_s rr[8] = '{'{APW_PER0_OFS, 32'h0000_00FF, APW_RESP_OK}, '{APW_PER1_OFS, 32'h0000_00FF, APW_RESP_OK},
      '{APW_ON0_OFS, 32'h0, APW_RESP_OK}, '{APW_ON1_OFS, 32'h0, APW_RESP_OK}, '{APW_MODE_OFS, 32'h0, APW_RESP_OK},
      '{APW_PSEL_OFS, 32'h0000_00FF, APW_RESP_OK}, '{APW_IOD1_OFS, 32'h2, APW_RESP_OK},
      '{8'h20, 32'h0, APW_RESP_ERR}};
   // offset rows keep the second period below the first, as software must
   apw_tb_pwm_s pr[5] = '{'{1'b1, 8'h05, 8'h03, 8'h03, 8'h02}, '{1'b1, 8'hFF, 8'h80, 8'h01, 8'h09},
      '{1'b1, 8'h02, 8'h00, 8'h00, 8'h01}, '{1'b0, 8'h07, 8'h02, 8'h02, 8'h03},
      '{1'b0, 8'h0A, 8'h0B, 8'h03, 8'h00}};
   apw_top apw_top_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gp_line_seven_i(gp7),
      .gp_line_eight_i(gp8), .pwm_out_first_o(pin0), .pwm_out_second_o(pin1), .pin_function_select_o(psel));
   apw_load_model load0_inst (.clk_i(mclk_i), .pin_i(pin0), .per_o(per0), .hi_o(hi0), .rise_o(r0));
   apw_load_model load1_inst (.clk_i(mclk_i), .pin_i(pin1), .per_o(per1), .hi_o(hi1), .rise_o(r1));
   always #10 mclk_i = ~mclk_i;
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // the whole run needs well under 10000 cycles
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         $display("[ERR] %0t run did not finish", $time);
         wrap_up();
      end
   end
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic check_int(input int got, input int exp, input string what);
      compares++;
      if (got != exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask
   // ready is looked at on the falling edge, where it is settled for the next rising one
   task automatic axi_write(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] r);
      logic ha, hw, hb;
      @(posedge mclk_i);
      awaddr <= a;
      wdata <= dv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge mclk_i);
         ha = awvalid && awready;
         hw = wvalid && wready;
         hb = bready && bvalid;
         r = bresp;
         @(posedge mclk_i);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) bready <= 1'b0;
      end while (!hb);
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] r);
      logic ha, hr;
      @(posedge mclk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge mclk_i);
         ha = arvalid && arready;
         hr = rready && rvalid;
         dv = rdata;
         r = rresp;
         @(posedge mclk_i);
         if (ha) arvalid <= 1'b0;
         if (hr) rready <= 1'b0;
      end while (!hr);
   endtask
   // constant levels are watched for a whole period, toggling ones measured by the load
   task automatic check_pwm(input int ch, input int ep, input int eh);
      int ok;
      ok = 1;
      if (eh == 0 || eh >= ep) begin
         repeat (ep) begin
            @(negedge mclk_i);
            if ((ch ? pin1 : pin0) !== (eh != 0)) ok = 0;
         end
         check_int(ok, 1, "constant level");
      end else begin
         check_int(ch ? per1 : per0, ep, "period");
         check_int(ch ? hi1 : hi0, eh, "high time");
      end
   endtask
   initial begin
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, gp7, gp8} = '0;
      wstrb = 4'hF;
      repeat (3) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         axi_read(rr[i].a, d, rs);
         check_val(d, rr[i].d, "reset value");
         check_val({30'h0, rs}, {30'h0, rr[i].r}, "read response");
      end
      check_val({24'h0, psel}, 32'h0000_00FF, "select pins after reset");
      check_val({30'h0, pin1, pin0}, 32'h0, "pins after reset");
      axi_write(8'h20, 32'h5A, rs);
      check_val({30'h0, rs}, {30'h0, APW_RESP_ERR}, "unmapped write");
      $display("test reset and map done");
      axi_write(APW_IOD1_OFS, 32'h0, rs);
      axi_write(APW_PSEL_OFS, 32'h7F, rs);
      for (int i = 0; i < 5; i++) begin
         axi_write(APW_MODE_OFS, {23'h0, pr[i].m, 8'h00}, rs);
         axi_write(APW_ON0_OFS, {24'h0, pr[i].c0}, rs);
         axi_write(APW_ON1_OFS, {24'h0, pr[i].c1}, rs);
         axi_write(APW_PER0_OFS, {24'h0, pr[i].p0}, rs);
         axi_write(APW_PER1_OFS, {24'h0, pr[i].p1}, rs);
         e0 = 2 * (pr[i].p0 + 1);
         e1 = pr[i].m ? 2 * (pr[i].p1 + 1) : e0;
         repeat (2 * e0 + 2 * e1 + 8) @(posedge mclk_i);
         check_pwm(0, e0, 2 * pr[i].c0);
         check_pwm(1, e1, 2 * pr[i].c1);
         if (!pr[i].m && pr[i].c1 != 0) check_int(((r1 - r0) % e0 + e0) % e0, 2 * (pr[i].p1 + 1), "offset");
         $display("test pwm row %0d done", i);
      end
      axi_write(APW_IOD1_OFS, 32'h2, rs);
      gp8 <= 1'b0;
      repeat (5) @(negedge mclk_i);
      check_val({31'h0, pin0}, 32'h0, "first pin as gpio low");
      @(posedge mclk_i);
      gp8 <= 1'b1;
      repeat (5) @(negedge mclk_i);
      check_val({31'h0, pin0}, 32'h1, "first pin as gpio high");
      axi_write(APW_PSEL_OFS, 32'hFF, rs);
      gp7 <= 1'b1;
      repeat (5) @(negedge mclk_i);
      check_val({31'h0, pin1}, 32'h1, "second pin as gpio");
      check_val({24'h0, psel}, 32'h0000_00FF, "select pins readback");
      axi_write(APW_IOD1_OFS, 32'h0, rs);
      $display("test pin routing done");
      axi_write(APW_MODE_OFS, 32'h100, rs);
      axi_write(APW_ON0_OFS, 32'h10, rs);
      axi_write(APW_PER0_OFS, 32'hFF, rs);
      repeat (4) @(negedge mclk_i);
      check_val({31'h0, pin0}, 32'h1, "high right after period write");
      repeat (40) @(negedge mclk_i);
      check_val({31'h0, pin0}, 32'h0, "low after on-time");
      axi_write(APW_ON0_OFS, 32'h80, rs);
      check_pwm(0, 100, 0);
      repeat (700) @(posedge mclk_i);
      check_int(hi0, 256, "new on-time at next cycle");
      axi_read(APW_ON0_OFS, d, rs);
      check_val(d, 32'h80, "on-time readback");
      $display("test on-time update done");
      wrap_up();
   end
endmodule
`default_nettype wire
